// File: dls_pkg.sv
package dls_pkg;

  // Error power width and register map (8-bit register port)
  localparam int unsigned ErrWidth      = 16;
  localparam logic [7:0]  RegErrPartA   = 8'h01;
  localparam logic [7:0]  RegErrPartB   = 8'h02;
  localparam logic [7:0]  RegStatus     = 8'h03;
  localparam logic [7:0]  RegReadZero   = 8'h00;

  // Status register bit positions
  localparam int unsigned StSegLockBit  = 0;
  localparam int unsigned StEqLockBit   = 1;
  localparam int unsigned StStateLoBit  = 2;

  // Reset values
  localparam logic [15:0] ErrResetValue = 16'hffff;
  localparam logic [15:0] ThresholdDef  = 16'h0400;

  // Timing: 20 MHz system clock
  localparam int unsigned ClockHz       = 20000000;
  localparam int unsigned OverTimeMs    = 100;
  localparam int unsigned OverCycles    = (ClockHz / 1000) * OverTimeMs;
  localparam int unsigned OverCntWidth  = 22;

  // Echo span and acquisition figures, kept for reference by the equalizer
  localparam real         PreEchoUs     = 2.32;
  localparam real         PostEchoUs    = 10.50;
  localparam int unsigned AcqTrainSeqs  = 12;
  localparam int unsigned AcqTimeMs     = 290;

  // Equalizer restart pulse lasts one symbol period (symbol strobe cycle)
  localparam int unsigned RestartSymbols = 1;

  typedef enum logic [1:0] {
    StAcquire,
    StTrain,
    StNormal
  } dls_state_t;

endpackage

// File: dls_lock_sequencer.sv
`timescale 1ns/100ps

// Behaviour
// R1: Equalizer spans 2.32 us pre-echo and 10.50 us post-echo; figures kept here.
// R2: Equalizer aims at visibility threshold within 12 training sequences, about 290 ms.
// R3: 16-bit error power from training versus output steers adaptation, host readable.
// R4: Acquisition order: tuner gain, coarse gain, timing/carrier, then segment lock.
// R5: After segment lock fine gain settles, field sync found, error power measured.
// R6: Back-end decoders start only after error power is low enough.
// R7: Exactly three states; any reset enters state 0, channel acquisition.
// R8: State 0 waits for gain, timing and carrier loops to lock.
// R9: Loss of segment lock or reset returns any state to state 0.
// R10: State 1 stays until error power falls below threshold, then state 2.
// R11: Back-end held in reset throughout state 1.
// R12: Error power readable at register addresses 01H and 02H.
// R13: State 2 holds while no synchronisation error occurs.
// R14: Error above threshold over 100 ms in state 2 resets equalizer one symbol.
// R15: Equalizer lock pin high in state 2, also host readable.
// R16: Segment lock pin follows sync recovery's segment sync detect, host readable.
// R17: Equalizer coefficients update once per symbol using training sequence.
// R18: Threshold is a parameter; 100 ms counted in system clock cycles.
// R19: Over-threshold timer clears when error drops or after each restart.
module dls_lock_sequencer #(
  parameter logic [15:0]          ErrThreshold = dls_pkg::ThresholdDef,
  parameter int unsigned          OverLimit    = dls_pkg::OverCycles
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic               symbolStrobe,
  input  wire logic               tunerGainLocked,
  input  wire logic               coarseGainLocked,
  input  wire logic               timingLocked,
  input  wire logic               carrierLocked,
  input  wire logic               segmentSyncFound,
  input  wire logic               fineGainLocked,
  input  wire logic               fieldSyncFound,
  input  wire logic               errValid,
  input  wire logic [15:0]        errPower,
  input  wire logic [7:0]         regAddr,
  output logic      [7:0]         regRdData,
  output logic                    segment_lock_flag,
  output logic                    equalizer_lock_flag,
  output logic                    backendResetN,
  output logic                    eqRestart,
  output logic                    eqAdaptEnable,
  output logic                    eqCoefUpdate,
  output logic      [1:0]         seqState
);
  import dls_pkg::*;

  dls_state_t                     state_q;
  dls_state_t                     state_d;
  logic       [15:0]              error_power_value_q;
  logic                           fieldSeen_q;
  logic       [OverCntWidth-1:0]  overCnt_q;
  logic                           restartPend_q;
  logic                           restart_q;
  logic                           segLock_q;
  logic                           eqLock_q;
  logic                           beRstN_q;
  logic       [7:0]               rdData_q;
  logic                           loopsLocked;
  logic                           belowThr;
  logic                           overExpired;
  logic       [3:0]               stageIn;
  logic       [3:0]               stageOk_q;
  logic       [7:0]               statusWord;
  logic       [7:0]               rdData_d;

  // Loop lock is a flat AND of the settled loops; acquisition order is kept by stageOk_q below
  assign loopsLocked = tunerGainLocked && coarseGainLocked // R4 R8
                    && timingLocked && carrierLocked;
  assign belowThr    = error_power_value_q < ErrThreshold; // R10 R18
  assign overExpired = overCnt_q >= OverCntWidth'(OverLimit - 1); // R14 R18

  // A stage counts only while every earlier stage holds, so a lock that is
  // reported out of order cannot shortcut the acquisition sequence
  assign stageIn = {segmentSyncFound, timingLocked && carrierLocked, coarseGainLocked,
                    tunerGainLocked}; // R4

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stageOk_q <= '0;
    end else begin
      stageOk_q <= stageIn & {stageOk_q[2:0], 1'b1}; // R4
    end
  end

  // Error power is latched from the training comparison each field
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      error_power_value_q <= ErrResetValue;
    end else if (errValid && fineGainLocked && segmentSyncFound) begin
      error_power_value_q <= errPower; // R3 R5
    end
  end

  // First field sync after segment lock arms the training state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fieldSeen_q <= 1'b0;
    end else if (!segmentSyncFound || state_q != StAcquire) begin
      fieldSeen_q <= 1'b0;
    end else if (fineGainLocked && fieldSyncFound && errValid) begin
      fieldSeen_q <= 1'b1; // R5
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      StAcquire: begin
        if (stageOk_q[3] && loopsLocked && segmentSyncFound && fieldSeen_q) begin
          state_d = StTrain; // R8
        end
      end
      StTrain: begin
        if (belowThr) begin
          state_d = StNormal; // R10
        end
      end
      StNormal: begin
        state_d = StNormal; // R13
      end
      default: begin
        state_d = StAcquire;
      end
    endcase
    if (!segmentSyncFound || !loopsLocked) begin
      state_d = StAcquire; // R9
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= StAcquire; // R7
    end else begin
      state_q <= state_d;
    end
  end

  // Over-threshold timer; only runs in normal operation
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      overCnt_q <= '0;
    end else if (state_q != StNormal || belowThr || restartPend_q || restart_q) begin
      overCnt_q <= '0; // R19
    end else if (!overExpired) begin
      overCnt_q <= overCnt_q + 1'b1; // R14
    end
  end

  // Restart waits for a symbol boundary so the pulse covers one whole symbol
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      restartPend_q <= 1'b0;
    end else if (state_q != StNormal || symbolStrobe) begin
      restartPend_q <= 1'b0;
    end else if (overExpired && !belowThr) begin
      restartPend_q <= 1'b1; // R14
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      restart_q <= 1'b0;
    end else if (symbolStrobe) begin
      restart_q <= restartPend_q && state_q == StNormal; // R14
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      segLock_q <= 1'b0;
    end else begin
      segLock_q <= segmentSyncFound; // R16
    end
  end

  // Lock flag and back-end release follow the next state so they agree with state 2
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      eqLock_q <= 1'b0;
    end else begin
      eqLock_q <= state_d == StNormal; // R15
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      beRstN_q <= 1'b0;
    end else begin
      beRstN_q <= state_d == StNormal; // R6 R11
    end
  end

  always_comb begin
    statusWord                    = '0;
    statusWord[StSegLockBit]      = segLock_q; // R16
    statusWord[StEqLockBit]       = eqLock_q; // R15
    statusWord[StStateLoBit +: 2] = 2'(state_q);
  end

  // Read port is combinationally decoded, registered once for a clean byte
  always_comb begin
    case (regAddr)
      RegErrPartA: rdData_d = error_power_value_q[15:8]; // R12
      RegErrPartB: rdData_d = error_power_value_q[7:0]; // R12
      RegStatus:   rdData_d = statusWord; // R15 R16
      default:     rdData_d = RegReadZero;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData           = rdData_q;
  assign segment_lock_flag   = segLock_q;
  assign equalizer_lock_flag = eqLock_q;
  assign backendResetN       = beRstN_q;
  assign eqRestart           = restart_q;
  // Adaptation in states 1 and 2 except while the restart pulse is high
  assign eqAdaptEnable       = (state_q != StAcquire) && !restart_q; // R1 R2
  assign eqCoefUpdate        = symbolStrobe && eqAdaptEnable; // R17
  assign seqState            = 2'(state_q);

endmodule

// File: dls_lock_monitor.sv
`timescale 1ns/100ps
module dls_lock_monitor (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       tunerGainLocked,
  input wire logic       coarseGainLocked,
  input wire logic       timingLocked,
  input wire logic       carrierLocked,
  input wire logic       segmentSyncFound,
  input wire logic       symbolStrobe,
  input wire logic       eqRestart,
  input wire logic       eqCoefUpdate,
  input wire logic       equalizer_lock_flag,
  input wire logic       segment_lock_flag,
  input wire logic       backendResetN,
  input wire logic [1:0] seqState
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic allLock;
  assign allLock = tunerGainLocked && coarseGainLocked && timingLocked && carrierLocked
                   && segmentSyncFound;
  property p_three; seqState != 2'h3; endproperty
  property p_start; $rose(rstn) |-> seqState == 2'h0; endproperty
  property p_loss; !allLock |=> seqState == 2'h0; endproperty
  property p_order; seqState == 2'h0 |=> seqState != 2'h2; endproperty
  property p_hold; seqState == 2'h2 && allLock |=> seqState == 2'h2; endproperty
  property p_back; seqState != 2'h2 |-> !backendResetN; endproperty
  property p_eqlk; equalizer_lock_flag == (seqState == 2'h2); endproperty
  property p_seg; segment_lock_flag == $past(segmentSyncFound); endproperty
  property p_coef;
    eqCoefUpdate == (symbolStrobe && seqState != 2'h0 && !eqRestart);
  endproperty
  property p_rst;
    $rose(eqRestart) |-> $past(symbolStrobe) && $past(seqState) == 2'h2;
  endproperty
  property p_rend; $fell(eqRestart) |-> $past(symbolStrobe); endproperty
  a_three: assert property (p_three) else $error("state code 3");
  a_start: assert property (p_start) else $error("not acquiring after reset");
  a_loss: assert property (p_loss) else $error("no fall back on lock loss");
  a_order: assert property (p_order) else $error("training skipped");
  a_hold: assert property (p_hold) else $error("normal state left");
  a_back: assert property (p_back) else $error("back end released early");
  a_eqlk: assert property (p_eqlk) else $error("eq lock flag wrong");
  a_seg: assert property (p_seg) else $error("segment flag wrong");
  a_coef: assert property (p_coef) else $error("coef update off strobe");
  a_rst: assert property (p_rst) else $error("restart start wrong");
  a_rend: assert property (p_rend) else $error("restart length wrong");
  c_norm: cover property (seqState == 2'h2);
  c_rst: cover property ($rose(eqRestart));
  c_loss: cover property (seqState == 2'h2 ##1 seqState == 2'h0);
endmodule
bind dls_lock_sequencer dls_lock_monitor dls_lock_monitor_i (.*);

// File: dls_far_side.sv
`timescale 1ns/100ps
module dls_far_side (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        lockReq,
  input  wire logic        measReq,
  input  wire logic [15:0] errIn,
  output logic             symbolStrobe,
  output logic [5:0]       lockQ,
  output logic             fieldSyncFound,
  output logic             errValid,
  output logic [15:0]      errPower
);
  logic [1:0]  div;
  logic [15:0] errQ;
  assign symbolStrobe = (div == 2'h0);
  // Stale bus shows inverted data so a late sample cannot pass
  assign errPower = errValid ? errQ : ~errQ;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div <= 2'h0;
      lockQ <= 6'h00;
    end else begin
      div <= div + 2'h1;
      lockQ <= lockReq ? {lockQ[4:0], 1'b1} : 6'h00;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      errValid <= 1'b0;
      fieldSyncFound <= 1'b0;
      errQ <= 16'h0000;
    end else begin
      errValid <= measReq;
      fieldSyncFound <= measReq;
      if (measReq) errQ <= errIn;
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  import dls_pkg::*;
  logic mclk, rstn, lockReq, measReq, symbolStrobe, fieldSyncFound, errValid;
  logic segment_lock_flag, equalizer_lock_flag, backendResetN, eqRestart;
  logic eqAdaptEnable, eqCoefUpdate;
  logic [5:0]  lk;
  logic [15:0] errIn, errPower;
  logic [7:0]  regAddr, regRdData;
  logic [1:0]  seqState;
  int          nFail, totalChecks, i;
  dls_far_side dls_far_side_i (.mclk(mclk), .rstn(rstn), .lockReq(lockReq),
    .measReq(measReq), .errIn(errIn), .symbolStrobe(symbolStrobe), .lockQ(lk),
    .fieldSyncFound(fieldSyncFound), .errValid(errValid), .errPower(errPower));
  dls_lock_sequencer #(.OverLimit(50)) dls_lock_sequencer_i (.mclk(mclk), .rstn(rstn),
    .symbolStrobe(symbolStrobe), .tunerGainLocked(lk[0]), .coarseGainLocked(lk[1]),
    .timingLocked(lk[2]), .carrierLocked(lk[3]), .segmentSyncFound(lk[4]),
    .fineGainLocked(lk[5]), .fieldSyncFound(fieldSyncFound), .errValid(errValid),
    .errPower(errPower), .regAddr(regAddr), .regRdData(regRdData),
    .segment_lock_flag(segment_lock_flag), .equalizer_lock_flag(equalizer_lock_flag),
    .backendResetN(backendResetN), .eqRestart(eqRestart), .eqAdaptEnable(eqAdaptEnable),
    .eqCoefUpdate(eqCoefUpdate), .seqState(seqState));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk) regAddr = a;
    @(negedge mclk) chk("register", exp, regRdData);
  endtask
  task automatic meas(input logic [15:0] e);
    @(negedge mclk) errIn = e;
    measReq = 1'b1;
    @(negedge mclk) measReq = 1'b0;
  endtask
  task automatic waitSt(input logic [1:0] s);
    for (i = 0; i < 20 && seqState !== s; i++) @(negedge mclk);
    chk("state", {6'h00, s}, {6'h00, seqState});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    nFail++;
    $display("Error watchdog expected done seen hang");
    give_verdict;
  end
  initial begin
    {rstn, lockReq, measReq, errIn, regAddr} = '0;
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    chk("state", 8'h00, {6'h00, seqState});
    rd(RegErrPartA, ErrResetValue[15:8]);
    lockReq = 1'b1;
    repeat (8) @(negedge mclk);
    meas(16'h0800);
    waitSt(2'h1);
    repeat (60) @(negedge mclk);
    chk("train", 8'h01, {6'h00, seqState});
    chk("backend", 8'h00, {7'h00, backendResetN});
    chk("adapt", 8'h01, {7'h00, eqAdaptEnable});
    rd(RegErrPartA, 8'h08);
    meas(16'h0123);
    waitSt(2'h2);
    chk("eqlock", 8'h01, {7'h00, equalizer_lock_flag});
    chk("backend", 8'h01, {7'h00, backendResetN});
    rd(RegErrPartB, 8'h23);
    rd(RegStatus, 8'h0b);
    rd(8'h10, 8'h00);
    meas(16'h0900);
    for (i = 0; i < 200 && eqRestart !== 1'b1; i++) @(negedge mclk);
    chk("restart", 8'h01, {7'h00, eqRestart});
    chk("normal", 8'h02, {6'h00, seqState});
    chk("adapt", 8'h00, {7'h00, eqAdaptEnable});
    @(negedge mclk) rstn = 1'b0;
    @(negedge mclk) chk("reset", 8'h00, {6'h00, seqState});
    chk("eqlock", 8'h00, {7'h00, equalizer_lock_flag});
    rstn = 1'b1;
    rd(RegErrPartA, ErrResetValue[15:8]);
    repeat (8) @(negedge mclk);
    chk("acquire", 8'h00, {6'h00, seqState});
    meas(16'h0100);
    waitSt(2'h2);
    lockReq = 1'b0;
    repeat (3) @(negedge mclk);
    chk("state", 8'h00, {6'h00, seqState});
    chk("seglock", 8'h00, {7'h00, segment_lock_flag});
    give_verdict;
  end
endmodule
